// file: comparator_defs.vh
// register indices, field positions and reset values of the comparator control block
`ifndef COMPARATOR_DEFS_VH
`define COMPARATOR_DEFS_VH

// register indices; byte address is four times the index
`define IDX_CMP_ONE_CFG        10'h001
`define IDX_CMP_TWO_CFG        10'h002
`define IDX_IRQ_EN_ZERO        10'h003
`define IDX_IRQ_EN_ONE         10'h004
`define IDX_EVT_STATUS         10'h005
`define IDX_EVT_MASK           10'h006
`define IDX_PIN_DIN_DISABLE    10'h0F6

// comparator configuration fields
`define CFG_CHANGE_FLAG        0
`define CFG_RESULT             1
`define CFG_PIN_OUT_EN         2
`define CFG_NEG_INTERNAL       3
`define CFG_POS_SEL_B          4
`define CFG_ENABLE             5

// interrupt enable fields
`define IRQ_ENABLE_REG_ZERO_GLOBAL            7
`define IRQ_ENABLE_REG_ONE_CMP_ONE           5
`define IRQ_ENABLE_REG_ONE_CMP_TWO           6

// event status and mask fields
`define EVT_CMP_ONE            0
`define EVT_CMP_TWO            1

// reset values
`define RST_CFG                8'h00
`define RST_IEN                8'h00
`define RST_DIN_DISABLE        8'h00
`define RST_EVT                2'h0

// bus answers
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

`endif

// file: comparator_control_irq.v
// comparator control, change flags, interrupt gating and wake-up with an AXI4-Lite slave
//
// Operation
// - each comparator sets its own change flag
// - request needs flag, own enable, global enable
// - comparators keep running in idle and power-down
// - enabled change wakes processor without clock
// - value 24h: on, input A, ref pin, pin out
// - flag is bit 0; writing back the value anded with 0feh clears only it
// - set bits disable matching port 0 digital inputs
// - single external input uses internal reference
// - positive inputs on port 0 bits 4, 3, 1
// - reference on bit 5, outputs on bits 6, 0
`include "comparator_defs.vh"

module comparator_control_irq #(
    parameter ADDR_W = 12
) (
    input  wire              aclk,
    input  wire              aresetn,
    // axi4-lite slave
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // analog comparator cores
    input  wire              cmp_one_result,
    input  wire              cmp_two_result,
    output wire              cmp_one_enable,
    output wire              cmp_two_enable,
    output wire              cmp_one_pos_sel_b,
    output wire              cmp_one_neg_internal,
    output wire              cmp_two_neg_internal,
    // port 0 pin side
    output wire              cmp_one_pin_out,
    output wire              cmp_one_pin_oe,
    output wire              cmp_two_pin_out,
    output wire              cmp_two_pin_oe,
    output wire [7:0]        analog_pin_digital_input_disable,
    // interrupt side
    output wire              cmp_one_irq_req,
    output wire              cmp_two_irq_req,
    output wire              cmp_wake,
    output wire              irq
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function [9:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            reg_index = addr[11:2];
        end
    endfunction

    function is_mapped;
        input [9:0] idx;
        begin
            case (idx)
                `IDX_CMP_ONE_CFG,
                `IDX_CMP_TWO_CFG,
                `IDX_IRQ_EN_ZERO,
                `IDX_IRQ_EN_ONE,
                `IDX_EVT_STATUS,
                `IDX_EVT_MASK,
                `IDX_PIN_DIN_DISABLE: is_mapped = 1'b1;
                default:              is_mapped = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg  [7:0]        cmp_one_cfg_q;
    reg  [7:0]        cmp_two_cfg_q;
    reg  [7:0]        irq_enable_reg_zero_q;
    reg  [7:0]        irq_enable_reg_one_q;
    reg  [7:0]        din_disable_q;
    reg  [1:0]        evt_status_q;
    reg  [1:0]        evt_mask_q;

    reg               aw_got_q;
    reg               w_got_q;
    reg  [ADDR_W-1:0] awaddr_q;
    reg  [31:0]       wdata_q;
    reg  [3:0]        wstrb_q;

    // comparator synchronisers and last sample
    reg               one_meta_q;
    reg               one_sync_q;
    reg               one_last_q;
    reg               two_meta_q;
    reg               two_sync_q;
    reg               two_last_q;

    wire              wr_fire;
    wire [9:0]        wr_idx;
    wire              wr_lane;
    wire              rd_fire;
    wire [9:0]        rd_idx;
    wire              rd_status;
    wire              one_change;
    wire              two_change;
    wire              global_irq_enable;
    wire              cmp_one_irq_enable;
    wire              cmp_two_irq_enable;

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
    assign wr_fire       = aw_got_q & w_got_q & ~s_axi_bvalid;
    assign wr_idx        = reg_index(awaddr_q);
    assign wr_lane       = wr_fire & wstrb_q[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            awaddr_q     <= {ADDR_W{1'b0}};
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid & s_axi_arready;
    assign rd_idx        = reg_index(s_axi_araddr);
    assign rd_status     = rd_fire & (rd_idx == `IDX_EVT_STATUS);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
            case (rd_idx)
                `IDX_CMP_ONE_CFG:     s_axi_rdata <= {24'h000000, cmp_one_cfg_q};
                `IDX_CMP_TWO_CFG:     s_axi_rdata <= {24'h000000, cmp_two_cfg_q};
                `IDX_IRQ_EN_ZERO:     s_axi_rdata <= {24'h000000, irq_enable_reg_zero_q};
                `IDX_IRQ_EN_ONE:      s_axi_rdata <= {24'h000000, irq_enable_reg_one_q};
                `IDX_EVT_STATUS:      s_axi_rdata <= {30'h0, evt_status_q};
                `IDX_EVT_MASK:        s_axi_rdata <= {30'h0, evt_mask_q};
                `IDX_PIN_DIN_DISABLE: s_axi_rdata <= {24'h000000, din_disable_q};
                default:              s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // comparator output synchronisers
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            one_meta_q <= 1'b0;
            one_sync_q <= 1'b0;
            one_last_q <= 1'b0;
            two_meta_q <= 1'b0;
            two_sync_q <= 1'b0;
            two_last_q <= 1'b0;
        end else begin
            one_meta_q <= cmp_one_result;
            one_sync_q <= one_meta_q;
            one_last_q <= one_sync_q;
            two_meta_q <= cmp_two_result;
            two_sync_q <= two_meta_q;
            two_last_q <= two_sync_q;
        end
    end

    // change only counts while the comparator is switched on
    assign one_change = cmp_one_cfg_q[`CFG_ENABLE] & (one_sync_q ^ one_last_q);
    assign two_change = cmp_two_cfg_q[`CFG_ENABLE] & (two_sync_q ^ two_last_q);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // result bit is read-only; a change wins over a software clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmp_one_cfg_q <= `RST_CFG;
            cmp_two_cfg_q <= `RST_CFG;
        end else begin
            if (wr_lane && wr_idx == `IDX_CMP_ONE_CFG) begin
                cmp_one_cfg_q <= wdata_q[7:0];
            end
            if (wr_lane && wr_idx == `IDX_CMP_TWO_CFG) begin
                cmp_two_cfg_q <= wdata_q[7:0];
            end
            cmp_one_cfg_q[`CFG_RESULT] <= one_sync_q;
            cmp_two_cfg_q[`CFG_RESULT] <= two_sync_q;
            if (one_change) begin
                cmp_one_cfg_q[`CFG_CHANGE_FLAG] <= 1'b1;
            end
            if (two_change) begin
                cmp_two_cfg_q[`CFG_CHANGE_FLAG] <= 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_reg_zero_q <= `RST_IEN;
            irq_enable_reg_one_q  <= `RST_IEN;
            din_disable_q         <= `RST_DIN_DISABLE;
            evt_mask_q            <= `RST_EVT;
        end else if (wr_lane) begin
            case (wr_idx)
                `IDX_IRQ_EN_ZERO:     irq_enable_reg_zero_q <= wdata_q[7:0];
                `IDX_IRQ_EN_ONE:      irq_enable_reg_one_q  <= wdata_q[7:0];
                `IDX_PIN_DIN_DISABLE: din_disable_q         <= wdata_q[7:0];
                `IDX_EVT_MASK:        evt_mask_q            <= wdata_q[1:0];
                default:              evt_mask_q            <= evt_mask_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sticky event status, cleared by reading it
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            evt_status_q <= `RST_EVT;
        end else begin
            evt_status_q <= (rd_status ? 2'b00 : evt_status_q) | {two_change, one_change};
        end
    end

    assign irq = |(evt_status_q & evt_mask_q);

    // ------------------------------------------------------------
    // interrupt requests and wake-up
    // ------------------------------------------------------------
    assign global_irq_enable  = irq_enable_reg_zero_q[`IRQ_ENABLE_REG_ZERO_GLOBAL];
    assign cmp_one_irq_enable = irq_enable_reg_one_q[`IRQ_ENABLE_REG_ONE_CMP_ONE];
    assign cmp_two_irq_enable = irq_enable_reg_one_q[`IRQ_ENABLE_REG_ONE_CMP_TWO];

    assign cmp_one_irq_req = cmp_one_cfg_q[`CFG_CHANGE_FLAG] & cmp_one_irq_enable
                             & global_irq_enable;
    assign cmp_two_irq_req = cmp_two_cfg_q[`CFG_CHANGE_FLAG] & cmp_two_irq_enable
                             & global_irq_enable;

    // raw compare against last sample works with the clock stopped
    assign cmp_wake = global_irq_enable & (
                      (cmp_one_irq_enable & cmp_one_cfg_q[`CFG_ENABLE]
                       & (cmp_one_result ^ one_last_q))
                    | (cmp_two_irq_enable & cmp_two_cfg_q[`CFG_ENABLE]
                       & (cmp_two_result ^ two_last_q))
                    | cmp_one_irq_req | cmp_two_irq_req);

    // ------------------------------------------------------------
    // analog routing and pins
    // ------------------------------------------------------------
    // enables depend on configuration only, never on power mode
    assign cmp_one_enable       = cmp_one_cfg_q[`CFG_ENABLE];
    assign cmp_two_enable       = cmp_two_cfg_q[`CFG_ENABLE];
    // 0 selects bit 4 (input a), 1 selects bit 3 (input b)
    assign cmp_one_pos_sel_b    = cmp_one_cfg_q[`CFG_POS_SEL_B];
    // 0 takes the reference pin on bit 5
    assign cmp_one_neg_internal = cmp_one_cfg_q[`CFG_NEG_INTERNAL];
    // comparator two has one external pin, bit 1, so always internal
    assign cmp_two_neg_internal = 1'b1;

    assign cmp_one_pin_out = one_sync_q;
    assign cmp_one_pin_oe  = cmp_one_cfg_q[`CFG_ENABLE] & cmp_one_cfg_q[`CFG_PIN_OUT_EN];
    assign cmp_two_pin_out = two_sync_q;
    assign cmp_two_pin_oe  = cmp_two_cfg_q[`CFG_ENABLE] & cmp_two_cfg_q[`CFG_PIN_OUT_EN];

    assign analog_pin_digital_input_disable = din_disable_q;

endmodule // comparator_control_irq

// file: cmp_ctl_chk.sv
// port assertions for the comparator control block
module cmp_ctl_chk (
    input wire       aclk,
    input wire       aresetn,
    input wire       s_axi_bvalid,
    input wire       s_axi_rvalid,
    input wire       cmp_one_result,
    input wire       cmp_one_enable,
    input wire       cmp_one_pin_out,
    input wire       cmp_one_pin_oe,
    input wire       cmp_two_neg_internal,
    input wire [7:0] analog_pin_digital_input_disable,
    input wire       cmp_one_irq_req,
    input wire       cmp_wake,
    input wire       irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // assertions
    // ----
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_pin_out_sync: assert property ($stable(cmp_one_result)[*3] |->
        cmp_one_pin_out == cmp_one_result) else $error("pin output not in sync");
    a_pin_oe_gate: assert property (cmp_one_pin_oe |-> cmp_one_enable)
        else $error("pin driven while off");
    a_req_hold: assert property (cmp_one_irq_req |=> cmp_one_irq_req ||
        $rose(s_axi_bvalid)) else $error("request dropped without write");
    a_req_cause: assert property ($rose(cmp_one_irq_req) |-> $rose(s_axi_bvalid) ||
        $past(cmp_one_pin_out) != $past(cmp_one_pin_out, 2)) else $error("request without cause");
    a_wake_req: assert property (cmp_one_irq_req |-> cmp_wake)
        else $error("request without wake");
    a_irq_hold: assert property (irq |=> irq || $rose(s_axi_bvalid) ||
        $rose(s_axi_rvalid)) else $error("irq dropped without access");
    a_int_ref: assert property (cmp_two_neg_internal)
        else $error("internal reference missing");
    a_din_write: assert property ($changed(analog_pin_digital_input_disable) |->
        $rose(s_axi_bvalid)) else $error("input disable changed alone");
    c_req: cover property ($rose(cmp_one_irq_req));
    c_irq: cover property ($rose(irq));
    c_wake: cover property ($rose(cmp_wake));
endmodule // cmp_ctl_chk

bind comparator_control_irq cmp_ctl_chk i_cmp_ctl_chk (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_rvalid, .cmp_one_result, .cmp_one_enable,
    .cmp_one_pin_out, .cmp_one_pin_oe, .cmp_two_neg_internal,
    .analog_pin_digital_input_disable, .cmp_one_irq_req, .cmp_wake, .irq
);

// file: cmp_core_model.sv
// analog comparator core: follows its level when on, noise when off
module cmp_core_model (
    input wire  aclk,
    input wire  on,
    input wire  level,
    output reg  result
);
    timeunit 1ns;
    timeprecision 1ns;
    initial result = 1'b0;
    // an unknown enable before reset counts as off, so the noise stays known
    always @(posedge aclk) begin
        if (on) begin
            result <= level;
        end else begin
            result <= ~result;
        end
    end
endmodule // cmp_core_model

// file: testbench.sv
// self-checking bench for the comparator control block
`include "comparator_defs.vh"
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, cmp_one_result, cmp_two_result, cmp_one_enable, cmp_two_enable;
    logic        cmp_one_pos_sel_b, cmp_one_neg_internal, cmp_two_neg_internal;
    logic        cmp_one_pin_out, cmp_one_pin_oe, cmp_two_pin_out, cmp_two_pin_oe;
    logic        cmp_one_irq_req, cmp_two_irq_req, cmp_wake, irq, lvl_one, lvl_two;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  analog_pin_digital_input_disable, v;
    logic [7:0]  cfgs [5] = '{8'h00, 8'h04, 8'h2C, 8'h34, 8'h24};
    int          error_cnt, total_checks;

    comparator_control_irq i_comparator_control_irq (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_one_result, .cmp_two_result,
        .cmp_one_enable, .cmp_two_enable, .cmp_one_pos_sel_b, .cmp_one_neg_internal,
        .cmp_two_neg_internal, .cmp_one_pin_out, .cmp_one_pin_oe, .cmp_two_pin_out,
        .cmp_two_pin_oe, .analog_pin_digital_input_disable, .cmp_one_irq_req,
        .cmp_two_irq_req, .cmp_wake, .irq
    );
    cmp_core_model i_cmp_core_model (.aclk, .on(cmp_one_enable), .level(lvl_one),
        .result(cmp_one_result));
    cmp_core_model i_cmp_core_model_two (.aclk, .on(cmp_two_enable), .level(lvl_two),
        .result(cmp_two_result));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // ----
    // bus tasks
    // ----
    task automatic wr(input [9:0] idx, input [7:0] d, input [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask
    task automatic rd(input [9:0] idx, input [7:0] m, input [7:0] e, input [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        v = s_axi_rdata[7:0];
        `CHK(s_axi_rdata & {24'hFFFFFF, m}, {24'h000000, e})
        `CHK(s_axi_rresp, er)
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge aclk);
        error_cnt++;
        test_done();
    end
    // ----
    // tests
    // ----
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, lvl_one, lvl_two, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`IDX_PIN_DIN_DISABLE, 8'hFF, `RST_DIN_DISABLE, `RESP_OKAY);
        wr(`IDX_PIN_DIN_DISABLE, 8'h30, `RESP_OKAY);
        rd(`IDX_PIN_DIN_DISABLE, 8'hFF, 8'h30, `RESP_OKAY);
        `CHK(analog_pin_digital_input_disable, 8'h30)
        // lane 0 strobe low: write ignored
        s_axi_wstrb <= 4'hE;
        wr(`IDX_PIN_DIN_DISABLE, 8'h5A, `RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        `CHK(analog_pin_digital_input_disable, 8'h30)
        wr(10'h007, 8'h5A, `RESP_SLVERR);
        rd(10'h007, 8'hFF, 8'h00, `RESP_SLVERR);
        foreach (cfgs[i]) begin
            v = cfgs[i];
            wr(`IDX_CMP_ONE_CFG, v, `RESP_OKAY);
            `CHK({cmp_one_enable, cmp_one_pos_sel_b, cmp_one_neg_internal}, v[5:3])
            `CHK({cmp_one_pin_oe, cmp_two_neg_internal}, {v[5] & v[2], 1'b1})
        end
        // start-up time: 250 cycles of 40 ns
        repeat (250) @(posedge aclk);
        rd(`IDX_CMP_ONE_CFG, 8'hFE, 8'h24, `RESP_OKAY);
        wr(`IDX_CMP_ONE_CFG, v & 8'hFE, `RESP_OKAY);
        rd(`IDX_CMP_ONE_CFG, 8'hFF, 8'h24, `RESP_OKAY);
        rd(`IDX_EVT_STATUS, 8'h00, 8'h00, `RESP_OKAY);
        wr(`IDX_IRQ_EN_ONE, 8'h20, `RESP_OKAY);
        wr(`IDX_IRQ_EN_ZERO, 8'h80, `RESP_OKAY);
        `CHK(cmp_one_irq_req, 1'b0)
        lvl_one <= 1'b1;
        // raw change wakes before the flag is sampled
        repeat (2) @(posedge aclk);
        `CHK({cmp_wake, cmp_one_irq_req}, 2'h2)
        repeat (4) @(posedge aclk);
        `CHK({cmp_one_pin_out, cmp_one_irq_req, cmp_wake, irq}, 4'hE)
        wr(`IDX_IRQ_EN_ZERO, 8'h00, `RESP_OKAY);
        `CHK(cmp_one_irq_req, 1'b0)
        wr(`IDX_IRQ_EN_ZERO, 8'h80, `RESP_OKAY);
        `CHK(cmp_one_irq_req, 1'b1)
        wr(`IDX_EVT_MASK, 8'h01, `RESP_OKAY);
        `CHK(irq, 1'b1)
        rd(`IDX_EVT_STATUS, 8'hFF, 8'h01, `RESP_OKAY);
        `CHK(irq, 1'b0)
        rd(`IDX_CMP_ONE_CFG, 8'hFF, 8'h27, `RESP_OKAY);
        wr(`IDX_CMP_ONE_CFG, v & 8'hFE, `RESP_OKAY);
        `CHK(cmp_one_irq_req, 1'b0)
        wr(`IDX_CMP_TWO_CFG, 8'h24, `RESP_OKAY);
        repeat (250) @(posedge aclk);
        wr(`IDX_CMP_TWO_CFG, 8'h24, `RESP_OKAY);
        rd(`IDX_EVT_STATUS, 8'h00, 8'h00, `RESP_OKAY);
        wr(`IDX_IRQ_EN_ONE, 8'h60, `RESP_OKAY);
        wr(`IDX_EVT_MASK, 8'h02, `RESP_OKAY);
        lvl_two <= 1'b1;
        repeat (6) @(posedge aclk);
        `CHK({cmp_two_pin_out, cmp_two_pin_oe, cmp_two_irq_req, irq}, 4'hF)
        rd(`IDX_EVT_STATUS, 8'hFF, 8'h02, `RESP_OKAY);
        wr(`IDX_CMP_ONE_CFG, 8'h00, `RESP_OKAY);
        repeat (20) @(posedge aclk);
        rd(`IDX_CMP_ONE_CFG, 8'h01, 8'h00, `RESP_OKAY);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK({irq, cmp_two_pin_oe, cmp_two_enable}, 3'h0)
        rd(`IDX_PIN_DIN_DISABLE, 8'hFF, `RST_DIN_DISABLE, `RESP_OKAY);
        test_done();
    end
endmodule // testbench
